// File: core/aos_defines.svh
// register offsets, field positions, reset values and address ranges of the setup bank
`ifndef AOS_DEFINES_SVH
`define AOS_DEFINES_SVH
`define AOS_IDX_ID_LOW      3'h0
`define AOS_IDX_ID_HIGH     3'h1
`define AOS_IDX_MODE        3'h2
`define AOS_IDX_ARB         3'h3
`define AOS_MODE_ENABLE_BIT 0
`define AOS_MODE_SEL_LSB    1
`define AOS_MODE_SEL_MSB    4
`define AOS_MODE_FIXED_ONE  8'h20
`define AOS_ARB_MASK        8'h0F
`define AOS_ARB_RESET       4'h0
`define AOS_MODE_RESET      4'h0
`define AOS_SDLC_BASE       16'h0380
`define AOS_BSC_BASE        16'h03A0
`define AOS_RANGE_MASK      16'hFFF0
`endif

// File: core/aos_pkg.sv
// types shared by the adapter option select bank
package aos_pkg;
   typedef enum logic [1:0] {AOS_MODE_SERIAL, AOS_MODE_SDLC, AOS_MODE_BSC, AOS_MODE_RSVD} aos_proto_t;
   typedef struct packed {
      logic       cs;
      logic       rd;
      logic       wr;
      logic [2:0] addr;
      logic [7:0] wdata;
   } aos_setup_req_t;
endpackage

// File: core/aos_option_bank.sv
// setup-time option select register bank with mode, port range and arbitration level
//
// Notes on behaviour
// - registers reachable only while slot_config_select_n is low
// - address lines 2..0 pick id low, id high, mode, arbitration
// - fixed sixteen bit id; index one high byte, index zero low byte
// - mode register bits 7..6 read zero, bit 5 reads one
// - mode field: serial one to eight, sdlc, alt sdlc, bsc, alt bsc
// - alternate bsc decodes 0380 range, alternate sdlc decodes 03A0 range
// - power-on clears mode bits 0 through 4
// - disabled adapter ignores io and memory commands except setup access
// - disabled adapter drives no interrupt request
// - channel reset clears adapter enable
// - power-on clears the whole arbitration register
// - arbitration register bits 7..4 read zero
// - arbitration level driven on priority lines when competing; zero wins
// - mode and arbitration registers write and read back
`include "aos_defines.svh"
module aos_option_bank
   import aos_pkg::*;
#(
   parameter logic [15:0] ADAPTER_ID = 16'h5A3C  // arbitrary value
)
(
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        chan_reset,
   input  wire logic        slot_config_select_n,
   input  wire logic        setup_rd,
   input  wire logic        setup_wr,
   input  wire logic [2:0]  setup_addr,
   input  wire logic [7:0]  setup_wdata,
   input  wire logic [15:0] io_addr,
   input  wire logic        io_cmd,
   input  wire logic        irq_req,
   input  wire logic        arb_compete,
   output logic      [7:0]  setup_rdata,
   output logic             io_select,
   output logic      [1:0]  proto_sel,
   output logic      [2:0]  serial_port,
   output logic             adapter_enabled,
   output logic             irq_out,
   output logic             irq_oe,
   output logic      [3:0]  arb_out,
   output logic      [3:0]  arb_oe
);

   // ----------------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------------
   logic [1:0]  sel_n_sync_reg;
   logic [1:0]  rd_sync_reg;
   logic [1:0]  wr_sync_reg;
   logic [1:0]  crst_sync_reg;
   logic [1:0]  cmp_sync_reg;
   logic [1:0]  cmd_sync_reg;
   logic [1:0]  irq_sync_reg;
   logic [2:0]  addr_s1_reg;
   logic [2:0]  addr_s2_reg;
   logic [7:0]  wd_s1_reg;
   logic [7:0]  wd_s2_reg;
   logic [15:0] ioa_s1_reg;
   logic [15:0] ioa_s2_reg;
   logic        wr_prev_reg;

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         sel_n_sync_reg <= 2'h3;
         rd_sync_reg    <= 2'h0;
         wr_sync_reg    <= 2'h0;
         crst_sync_reg  <= 2'h0;
         cmp_sync_reg   <= 2'h0;
         cmd_sync_reg   <= 2'h0;
         irq_sync_reg   <= 2'h0;
         addr_s1_reg    <= 3'h0;
         addr_s2_reg    <= 3'h0;
         wd_s1_reg      <= 8'h00;
         wd_s2_reg      <= 8'h00;
         ioa_s1_reg     <= 16'h0000;
         ioa_s2_reg     <= 16'h0000;
         wr_prev_reg    <= 1'b0;
      end
      else
      begin
         sel_n_sync_reg <= {sel_n_sync_reg[0], slot_config_select_n};
         rd_sync_reg    <= {rd_sync_reg[0], setup_rd};
         wr_sync_reg    <= {wr_sync_reg[0], setup_wr};
         crst_sync_reg  <= {crst_sync_reg[0], chan_reset};
         cmp_sync_reg   <= {cmp_sync_reg[0], arb_compete};
         cmd_sync_reg   <= {cmd_sync_reg[0], io_cmd};
         irq_sync_reg   <= {irq_sync_reg[0], irq_req};
         addr_s1_reg    <= setup_addr;
         addr_s2_reg    <= addr_s1_reg;
         wd_s1_reg      <= setup_wdata;
         wd_s2_reg      <= wd_s1_reg;
         ioa_s1_reg     <= io_addr;
         ioa_s2_reg     <= ioa_s1_reg;
         wr_prev_reg    <= wr_sync_reg[1];
      end
   end

   // ----------------------------------------------------------------------
   // setup access decode
   // ----------------------------------------------------------------------
   aos_setup_req_t req;
   assign req.cs    = ~sel_n_sync_reg[1];
   assign req.rd    = rd_sync_reg[1];
   assign req.wr    = wr_sync_reg[1] & ~wr_prev_reg;
   assign req.addr  = addr_s2_reg;
   assign req.wdata = wd_s2_reg;

   wire hit_mode = req.cs & req.wr & (req.addr == `AOS_IDX_MODE);
   wire hit_arb  = req.cs & req.wr & (req.addr == `AOS_IDX_ARB);

   // ----------------------------------------------------------------------
   // option and arbitration registers
   // ----------------------------------------------------------------------
   logic       enable_reg;
   logic [3:0] mode_reg;
   logic [3:0] arb_reg;

   // id registers have no storage, so writes there fall through
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         enable_reg <= 1'b0;
         mode_reg   <= `AOS_MODE_RESET;
         arb_reg    <= `AOS_ARB_RESET;
      end
      else
      begin
         if (crst_sync_reg[1])
            enable_reg <= 1'b0;
         else if (hit_mode)
            enable_reg <= req.wdata[`AOS_MODE_ENABLE_BIT];
         if (hit_mode)
            mode_reg <= req.wdata[`AOS_MODE_SEL_MSB:`AOS_MODE_SEL_LSB];
         if (hit_arb)
            arb_reg <= req.wdata[3:0];
      end
   end

   // ----------------------------------------------------------------------
   // read mux
   // ----------------------------------------------------------------------
   wire [7:0] mode_rd = `AOS_MODE_FIXED_ONE | {3'h0, mode_reg, enable_reg};
   wire [7:0] arb_rd  = {4'h0, arb_reg} & `AOS_ARB_MASK;
   logic [7:0] rd_sel;
   always_comb
   begin
      case (req.addr)
         `AOS_IDX_ID_LOW:  rd_sel = ADAPTER_ID[7:0];
         `AOS_IDX_ID_HIGH: rd_sel = ADAPTER_ID[15:8];
         `AOS_IDX_MODE:    rd_sel = mode_rd;
         `AOS_IDX_ARB:     rd_sel = arb_rd;
         default:          rd_sel = 8'h00;
      endcase
   end

   // ----------------------------------------------------------------------
   // mode and port address decode
   // ----------------------------------------------------------------------
   aos_proto_t proto;
   logic       alt;
   always_comb
   begin
      alt = mode_reg[0];
      case (mode_reg)
         4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7: proto = AOS_MODE_SERIAL;
         4'h8, 4'h9:                                     proto = AOS_MODE_SDLC;
         4'hC, 4'hD:                                     proto = AOS_MODE_BSC;
         default:                                        proto = AOS_MODE_RSVD;
      endcase
   end

   wire [15:0] sync_base = ((proto == AOS_MODE_SDLC) ^ alt) ? `AOS_SDLC_BASE
                                                            : `AOS_BSC_BASE;
   wire sync_hit = ((proto == AOS_MODE_SDLC) | (proto == AOS_MODE_BSC))
                 & ((ioa_s2_reg & `AOS_RANGE_MASK) == sync_base);
   wire io_hit   = enable_reg & cmd_sync_reg[1] & sync_hit & sel_n_sync_reg[1];

   // ----------------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         setup_rdata     <= 8'h00;
         io_select       <= 1'b0;
         proto_sel       <= 2'h0;
         serial_port     <= 3'h0;
         adapter_enabled <= 1'b0;
         irq_out         <= 1'b0;
         irq_oe          <= 1'b0;
         arb_out         <= 4'h0;
         arb_oe          <= 4'h0;
      end
      else
      begin
         setup_rdata     <= (req.cs & req.rd) ? rd_sel : 8'h00;
         io_select       <= io_hit;
         proto_sel       <= proto;
         serial_port     <= mode_reg[2:0];
         adapter_enabled <= enable_reg;
         irq_out         <= irq_sync_reg[1];
         irq_oe          <= enable_reg & irq_sync_reg[1];
         arb_out         <= arb_reg;
         arb_oe          <= (cmp_sync_reg[1] & enable_reg) ? ~arb_reg : 4'h0;
      end
   end

endmodule // aos_option_bank

// File: tb/aos_arb_model.sv
// channel arbiter model: open-drain priority lines shared with one rival requester
module aos_arb_model
(
   input  wire logic [3:0] arb_oe,
   input  wire logic [3:0] rival_level,
   output logic      [3:0] arb_bus,
   output logic            own_wins
);
   timeunit 1ns;
   timeprecision 1ps;
   // pulled-up lines; each requester pulls low where its level bit is zero
   assign arb_bus  = ~arb_oe & rival_level;
   assign own_wins = (arb_oe != 4'h0) && (arb_bus == ~arb_oe);
endmodule // aos_arb_model

// File: tb/aos_option_bank_assertions.sv
// port assertions for the option select bank
module aos_option_bank_assertions
#(
   parameter logic [15:0] ADAPTER_ID = 16'h5A3C  // arbitrary value
)
(
   input wire logic       clk,
   input wire logic       rst,
   input wire logic       chan_reset,
   input wire logic       slot_config_select_n,
   input wire logic       setup_rd,
   input wire logic [2:0] setup_addr,
   input wire logic [7:0] setup_rdata,
   input wire logic       io_select,
   input wire logic       adapter_enabled,
   input wire logic       irq_oe,
   input wire logic [3:0] arb_out,
   input wire logic [3:0] arb_oe
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   sequence rd_hold(logic [2:0] a);
      (!slot_config_select_n && setup_rd && setup_addr == a) [*4];
   endsequence
   sel_gates_read_a: assert property (setup_rdata != 8'h00 |-> !$past(slot_config_select_n, 3))
      else $error("read data without setup select");
   id_low_a: assert property (rd_hold(3'h0) |-> setup_rdata == ADAPTER_ID[7:0])
      else $error("id low byte wrong");
   id_high_a: assert property (rd_hold(3'h1) |-> setup_rdata == ADAPTER_ID[15:8])
      else $error("id high byte wrong");
   mode_fixed_a: assert property (rd_hold(3'h2) |-> setup_rdata[7:5] == 3'b001)
      else $error("mode fixed bits wrong");
   arb_upper_a: assert property (rd_hold(3'h3) |-> setup_rdata[7:4] == 4'h0)
      else $error("arbitration upper bits set");
   quiet_io_a: assert property (!adapter_enabled [*2] |-> !io_select && !irq_oe)
      else $error("disabled adapter responds");
   quiet_arb_a: assert property (!adapter_enabled [*2] |-> arb_oe == 4'h0)
      else $error("disabled adapter drives priority lines");
   arb_lines_a: assert property (arb_oe != 4'h0 |-> arb_oe == ~arb_out)
      else $error("priority lines differ from level");
   chan_clear_a: assert property (chan_reset [*3] |-> ##[1:2] !adapter_enabled)
      else $error("channel reset left adapter enabled");
   power_on_a: assert property ($fell(rst) |-> !adapter_enabled && arb_out == 4'h0)
      else $error("power-on values wrong");
   cover property (rd_hold(3'h2));
   cover property (io_select);
   cover property (arb_oe != 4'h0);
endmodule // aos_option_bank_assertions
bind aos_option_bank aos_option_bank_assertions #(.ADAPTER_ID(ADAPTER_ID)) chk (.*);

// File: tb/aos_option_bank_tb.sv
// self-checking bench for the option select bank
module aos_option_bank_tb
   import aos_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [15:0] ID = 16'h96C3;  // arbitrary value
   logic clk = 0, rst = 1, chan_reset = 0, irq_req = 0, arb_compete = 0;
   logic io_select, adapter_enabled, irq_out, irq_oe, won;
   logic [15:0] io_addr = 16'h0000;
   logic io_cmd = 1'b0;
   logic [7:0] rdata;
   logic [3:0] arb_out, arb_oe, arb_bus, rival = 4'hF;
   logic [2:0] serial_port;
   logic [1:0] proto_sel;
   aos_setup_req_t req = '0;
   int fail_count = 0, samples_checked = 0;
   always #20 clk = ~clk;
   aos_option_bank #(.ADAPTER_ID(ID)) dut
   (
      .clk(clk), .rst(rst), .chan_reset(chan_reset), .slot_config_select_n(!req.cs),
      .setup_rd(req.rd), .setup_wr(req.wr), .setup_addr(req.addr), .setup_wdata(req.wdata),
      .io_addr(io_addr), .io_cmd(io_cmd), .irq_req(irq_req), .arb_compete(arb_compete),
      .setup_rdata(rdata), .io_select(io_select), .proto_sel(proto_sel),
      .serial_port(serial_port), .adapter_enabled(adapter_enabled), .irq_out(irq_out),
      .irq_oe(irq_oe), .arb_out(arb_out), .arb_oe(arb_oe)
   );
   aos_arb_model arb (.arb_oe(arb_oe), .rival_level(rival), .arb_bus(arb_bus), .own_wins(won));
   task automatic tick(int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic cmp(string what, logic [7:0] exp, logic [7:0] got);
      samples_checked++;
      if (got !== exp)
      begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr(logic [2:0] a, logic [7:0] d, logic cs = 1'b1);
      @(posedge clk) req <= '{cs, 1'b0, 1'b1, a, d};
      tick(3);
      req <= '{cs, 1'b0, 1'b0, a, d};
      tick(3);
      req <= '0;
   endtask
   task automatic rd(string what, logic [2:0] a, logic [7:0] exp, logic cs = 1'b1);
      @(posedge clk) req <= '{cs, 1'b1, 1'b0, a, 8'h00};
      tick(4);
      cmp(what, exp, rdata);
      req <= '0;
   endtask
   task automatic io(logic [15:0] a);
      @(posedge clk) io_addr <= a;
      io_cmd <= 1'b1;
      tick(4);
      io_cmd <= 1'b0;
   endtask
   task automatic t_ident();
      rd("mode", 3'h2, 8'h20);
      rd("arb", 3'h3, 8'h00);
      wr(3'h0, ~ID[7:0]);
      wr(3'h1, ~ID[15:8]);
      rd("id low", 3'h0, ID[7:0]);
      rd("id high", 3'h1, ID[15:8]);
      rd("mode kept", 3'h2, 8'h20);
      wr(3'h2, 8'hFF);
      rd("mode all", 3'h2, 8'h3F);
      wr(3'h3, 8'hFF);
      rd("arb all", 3'h3, 8'h0F);
      $display("done ident");
   endtask
   task automatic t_modes();
      logic [3:0] c;
      for (int i = 0; i < 16; i++)
      begin
         c = i[3:0];
         wr(3'h2, {3'b001, c, 1'b1});
         io(16'h0385);
         cmp("hit 0380", {7'h0, c == 4'h8 || c == 4'hD}, {7'h0, io_select});
         io(16'h03A5);
         cmp("hit 03A0", {7'h0, c == 4'h9 || c == 4'hC}, {7'h0, io_select});
         cmp("proto", c[3] ? (c[1] ? 8'h3 : (c[2] ? 8'h2 : 8'h1)) : 8'h0, {6'h0, proto_sel});
         if (!c[3])
            cmp("port", {5'h0, c[2:0]}, {5'h0, serial_port});
      end
      $display("done modes");
   endtask
   task automatic t_enable();
      wr(3'h3, 8'h01);
      wr(3'h2, 8'h30);
      @(posedge clk) irq_req <= 1'b1;
      arb_compete <= 1'b1;
      io(16'h0385);
      cmp("off sel", 8'h00, {7'h0, io_select});
      cmp("off irq", 8'h00, {7'h0, irq_oe});
      cmp("off arb", 8'h00, {4'h0, arb_oe});
      wr(3'h2, 8'h31);
      io(16'h0385);
      cmp("on sel", 8'h01, {7'h0, io_select});
      cmp("on irq", 8'h01, {7'h0, irq_oe});
      cmp("irq out", 8'h01, {7'h0, irq_out});
      cmp("on arb", 8'h0E, {4'h0, arb_oe});
      cmp("arb level", 8'h01, {4'h0, arb_out});
      tick(4);
      cmp("no cmd sel", 8'h00, {7'h0, io_select});
      cmp("win", 8'h01, {7'h0, won});
      @(posedge clk) rival <= 4'h0;
      tick(1);
      cmp("lose", 8'h00, {7'h0, won});
      wr(3'h3, 8'h05, 1'b0);
      rd("arb kept", 3'h3, 8'h01);
      rd("idle read", 3'h3, 8'h00, 1'b0);
      @(posedge clk) chan_reset <= 1'b1;
      tick(3);
      chan_reset <= 1'b0;
      tick(2);
      cmp("ch reset", 8'h00, {7'h0, adapter_enabled});
      rd("mode off", 3'h2, 8'h30);
      $display("done enable");
   endtask
   task automatic stop_test();
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   initial
   begin
      tick(10);
      rst <= 1'b0;
      tick(2);
      t_ident();
      t_modes();
      t_enable();
      stop_test();
   end
   initial
   begin
      tick(20000);
      fail_count++;
      stop_test();
   end
endmodule // aos_option_bank_tb
